// file: gpio_pad_board.sv
// Purpose: Board circuitry on the twelve pins.
// Assumes: Strong drive beats an external source, which beats a lone weak pull.
// Notes: A floating pin wanders every cycle so a stale level never passes as real.
`timescale 1ns/1ps
`default_nettype none
module gpio_pad_board (
  input wire logic clk,
  input wire logic [11:0] padOut,
  input wire logic [11:0] padOe,
  input wire logic [11:0] padWeakUp,
  input wire logic [11:0] padWeakDown,
  input wire logic [11:0] extEn,
  input wire logic [11:0] extVal,
  output logic [11:0] padIn
);
  logic floatQ = 1'b0;
  // Pattern for undriven pins.
  always_ff @(posedge clk) begin
    floatQ <= ~floatQ;
  end
  // Resolve each wire from all its drivers.
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      if (padOe[i]) padIn[i] = padOut[i];
      else if (extEn[i]) padIn[i] = extVal[i];
      else if (padWeakUp[i] != padWeakDown[i]) padIn[i] = padWeakUp[i];
      else padIn[i] = floatQ ^ i[0];
    end
  end
endmodule
`default_nettype wire

// file: gpio_pin_cell.sv
// Purpose: One pin's drive decoder with a hold latch on its pad controls.
// Assumes: Control inputs are synchronous to clk.
// Notes: While hold is high the registered pad controls keep their last value.
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_cell (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hold,
  input var gpio_port_pkg::pin_ctrl_type ctrl,
  output gpio_port_pkg::pad_drive_type drive_q
);
  gpio_port_pkg::pad_drive_type drive_d;

  // Decode the drive configuration into strong and weak pad drivers.
  always_comb begin
    drive_d = '0;
    drive_d.inEn = ctrl.inEn && (ctrl.mode != gpio_port_pkg::MODE_ANALOG);
    drive_d.strongOut = ctrl.dout;
    if (ctrl.outEn) begin
      case (ctrl.mode)
        gpio_port_pkg::MODE_WUP_SDN: begin
          drive_d.strongOe = !ctrl.dout;
          drive_d.weakUp = ctrl.dout;
        end
        gpio_port_pkg::MODE_SUP_WDN: begin
          drive_d.strongOe = ctrl.dout;
          drive_d.weakDown = !ctrl.dout;
        end
        gpio_port_pkg::MODE_OD_SDN: begin
          drive_d.strongOe = !ctrl.dout;
        end
        gpio_port_pkg::MODE_OD_SUP: begin
          drive_d.strongOe = ctrl.dout;
        end
        gpio_port_pkg::MODE_SUP_SDN: begin
          drive_d.strongOe = 1'b1;
        end
        gpio_port_pkg::MODE_WUP_WDN: begin
          drive_d.weakUp = ctrl.dout;
          drive_d.weakDown = !ctrl.dout;
        end
        default: begin
          drive_d.strongOe = 1'b0;
        end
      endcase
    end
  end

  // Register the pad controls; reset turns every buffer off, hold freezes them.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      drive_q <= '0;
    end else if (!hold) begin
      drive_q <= drive_d;
    end
  end
endmodule
`default_nettype wire

// file: gpio_port.sv
// Purpose: Twelve-pin general-purpose I/O block in three 8-bit ports behind Wishbone.
// Assumes: Pad inputs are synchronous to clk; peripheral sources are synchronous too.
// Notes: Pins sit on bits 0 to 3 of each port; other bits read as zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Twelve pins exist, each configured on its own.
// - Eight drive configurations, from analog off through pull and open-drain combinations.
// - Each pin selects CMOS or LVTTL input threshold.
// - Input and output buffers are enabled separately from the drive configuration.
// - Hold freezes each pin's state so it survives sleep modes.
// - Each pin's output slew rate is selectable.
// - Pins group into 8-bit ports; registers address pins by bit position.
// - During reset every pin buffer is forced off.
// - A source matrix picks which internal signal drives each pin.
// - Output data register drives pins; pin state register reads sampled levels.
// - A pin raises an interrupt event only when enabled.
// - Pin interrupts merge into one request per port, three in all.
module gpio_port (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [gpio_port_pkg::ADR_BITS-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [gpio_port_pkg::DAT_BITS-1:0] wb_dat_i,
  output logic [gpio_port_pkg::DAT_BITS-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [gpio_port_pkg::NUM_PINS-1:0] padIn,
  output logic [gpio_port_pkg::NUM_PINS-1:0] padOut,
  output logic [gpio_port_pkg::NUM_PINS-1:0] padOe,
  output logic [gpio_port_pkg::NUM_PINS-1:0] padWeakUp,
  output logic [gpio_port_pkg::NUM_PINS-1:0] padWeakDown,
  output logic [gpio_port_pkg::NUM_PINS-1:0] padInEn,
  output logic [gpio_port_pkg::NUM_PINS-1:0] padLvttl,
  output logic [gpio_port_pkg::NUM_PINS-1:0] padSlewFast,
  input wire logic [gpio_port_pkg::NUM_SOURCES-1:0][gpio_port_pkg::NUM_PINS-1:0] periphOut,
  output logic [gpio_port_pkg::NUM_PINS-1:0] pinLevel,
  output logic [gpio_port_pkg::NUM_PORTS-1:0] portIrq,
  output logic irq
);
  localparam int NP = gpio_port_pkg::NUM_PORTS;
  localparam int PPP = gpio_port_pkg::PINS_PER_PORT;

  // Register state, one entry per port for configuration and interrupts; hold, pin samples and bus state are single.
  logic [7:0] dataOut_q [NP];
  logic [23:0] driveMode_q [NP];
  logic [31:0] bufCtrl_q [NP];
  logic [15:0] srcSel_q [NP];
  logic [7:0] intEn_q [NP];
  logic [7:0] intMask_q [NP];
  logic [7:0] intStat_q [NP];
  logic hold_q;
  logic [gpio_port_pkg::NUM_PINS-1:0] pinState_q;
  logic [gpio_port_pkg::NUM_PINS-1:0] pinPrev_q;
  logic ack_q;
  logic [31:0] rdData_q;
  logic [31:0] rdData_d;

  // Bus decode.
  logic access;
  logic wrStrobe;
  logic [1:0] portSel;
  logic [4:0] regOfs;
  logic portHit;
  logic holdHit;
  logic [31:0] wrMask;

  gpio_port_pkg::pad_drive_type drive [gpio_port_pkg::NUM_PINS];
  gpio_port_pkg::pin_ctrl_type ctrl [gpio_port_pkg::NUM_PINS];
  logic [gpio_port_pkg::NUM_PINS-1:0] pinEvent;

  // Expand byte selects into a bit mask.
  function automatic logic [31:0] sel_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction

  // Merge a write into a stored word under byte selects and the field mask.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
                                        input logic [31:0] m, input logic [31:0] fmask);
    return ((old & ~m) | (wdat & m)) & fmask;
  endfunction

  // Address decode: port windows are 0x20 bytes, registers one aligned word each.
  always_comb begin
    access = wb_cyc_i && wb_stb_i;
    portSel = wb_adr_i[6:5];
    regOfs = wb_adr_i[4:0];
    portHit = !wb_adr_i[7] && (portSel < 2'(NP));
    holdHit = (wb_adr_i == gpio_port_pkg::ADR_HOLD);
    wrMask = sel_mask(wb_sel_i);
    wrStrobe = access && wb_we_i && ack_q;
  end

  // Acknowledge one cycle after the request; drop it the cycle after.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access && !ack_q;
    end
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    rdData_d = '0;
    if (holdHit) begin
      rdData_d[0] = hold_q;
    end else if (portHit) begin
      case (regOfs)
        gpio_port_pkg::OFS_DATA_OUT: rdData_d[7:0] = dataOut_q[portSel];
        gpio_port_pkg::OFS_PIN_STATE: rdData_d[PPP-1:0] = pinState_q[portSel*PPP +: PPP];
        gpio_port_pkg::OFS_DRIVE_MODE: rdData_d[23:0] = driveMode_q[portSel];
        gpio_port_pkg::OFS_BUF_CTRL: rdData_d = bufCtrl_q[portSel];
        gpio_port_pkg::OFS_SRC_SEL: rdData_d[15:0] = srcSel_q[portSel];
        gpio_port_pkg::OFS_INT_EN: rdData_d[7:0] = intEn_q[portSel];
        gpio_port_pkg::OFS_INT_STATUS: rdData_d[7:0] = intStat_q[portSel];
        gpio_port_pkg::OFS_INT_MASK: rdData_d[7:0] = intMask_q[portSel];
        default: rdData_d = '0;
      endcase
    end
  end

  // Capture read data together with the acknowledge.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdData_q <= '0;
    end else if (access && !ack_q) begin
      rdData_q <= rdData_d;
    end
  end

  assign wb_dat_o = rdData_q;
  assign wb_ack_o = ack_q;

  // Configuration registers; a write takes effect on the edge that sees ack high.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int p = 0; p < NP; p++) begin
        dataOut_q[p] <= gpio_port_pkg::RST_DATA_OUT;
        driveMode_q[p] <= gpio_port_pkg::RST_DRIVE_MODE;
        bufCtrl_q[p] <= gpio_port_pkg::RST_BUF_CTRL;
        srcSel_q[p] <= gpio_port_pkg::RST_SRC_SEL;
        intEn_q[p] <= gpio_port_pkg::RST_INT;
        intMask_q[p] <= gpio_port_pkg::RST_INT;
      end
    end else if (wrStrobe && portHit) begin
      case (regOfs)
        gpio_port_pkg::OFS_DATA_OUT: begin
          dataOut_q[portSel] <= 8'(merge(32'(dataOut_q[portSel]), wb_dat_i, wrMask,
                                         32'(gpio_port_pkg::PIN_MASK)));
        end
        gpio_port_pkg::OFS_DRIVE_MODE: begin
          driveMode_q[portSel] <= 24'(merge(32'(driveMode_q[portSel]), wb_dat_i, wrMask,
                                            32'(gpio_port_pkg::MODE_MASK)));
        end
        gpio_port_pkg::OFS_BUF_CTRL: begin
          bufCtrl_q[portSel] <= merge(bufCtrl_q[portSel], wb_dat_i, wrMask,
                                      gpio_port_pkg::BUF_MASK);
        end
        gpio_port_pkg::OFS_SRC_SEL: begin
          srcSel_q[portSel] <= 16'(merge(32'(srcSel_q[portSel]), wb_dat_i, wrMask,
                                         32'(gpio_port_pkg::SEL_MASK)));
        end
        gpio_port_pkg::OFS_INT_EN: begin
          intEn_q[portSel] <= 8'(merge(32'(intEn_q[portSel]), wb_dat_i, wrMask,
                                       32'(gpio_port_pkg::PIN_MASK)));
        end
        gpio_port_pkg::OFS_INT_MASK: begin
          intMask_q[portSel] <= 8'(merge(32'(intMask_q[portSel]), wb_dat_i, wrMask,
                                         32'(gpio_port_pkg::PIN_MASK)));
        end
        default: begin
          dataOut_q[portSel] <= dataOut_q[portSel];
        end
      endcase
    end
  end

  // Global hold control for low-power retention.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hold_q <= 1'b0;
    end else if (wrStrobe && holdHit && wb_sel_i[0]) begin
      hold_q <= wb_dat_i[0];
    end
  end

  // Build each pin's control word from its port bit position and the source matrix.
  always_comb begin
    for (int i = 0; i < gpio_port_pkg::NUM_PINS; i++) begin
      automatic int p = i / PPP;
      automatic int b = i % PPP;
      automatic logic [1:0] src = srcSel_q[p][b*2 +: 2];
      ctrl[i].mode = driveMode_q[p][b*3 +: 3];
      ctrl[i].inEn = bufCtrl_q[p][gpio_port_pkg::BUF_IE_POS + b];
      ctrl[i].outEn = bufCtrl_q[p][gpio_port_pkg::BUF_OE_POS + b];
      if (src == 2'h0) begin
        ctrl[i].dout = dataOut_q[p][b];
      end else begin
        ctrl[i].dout = periphOut[src - 2'h1][i];
      end
    end
  end

  // One drive cell per pin.
  for (genvar g = 0; g < gpio_port_pkg::NUM_PINS; g++) begin : g_pin
    gpio_pin_cell u_cell (
      .clk(clk),
      .reset_n(reset_n),
      .hold(hold_q),
      .ctrl(ctrl[g]),
      .drive_q(drive[g])
    );
  end

  // Threshold and slew controls are registered and frozen by hold like the drivers.
  always_ff @(posedge clk) begin
    for (int i = 0; i < gpio_port_pkg::NUM_PINS; i++) begin
      if (!reset_n) begin
        padLvttl[i] <= 1'b0;
        padSlewFast[i] <= 1'b0;
      end else if (!hold_q) begin
        padLvttl[i] <= bufCtrl_q[i / PPP][gpio_port_pkg::BUF_LVTTL_POS + i % PPP];
        padSlewFast[i] <= bufCtrl_q[i / PPP][gpio_port_pkg::BUF_SLEW_POS + i % PPP];
      end
    end
  end

  // Pad outputs; reset gates every enable off at once.
  always_comb begin
    for (int i = 0; i < gpio_port_pkg::NUM_PINS; i++) begin
      padOut[i] = drive[i].strongOut;
      padOe[i] = drive[i].strongOe && reset_n;
      padWeakUp[i] = drive[i].weakUp && reset_n;
      padWeakDown[i] = drive[i].weakDown && reset_n;
      padInEn[i] = drive[i].inEn && reset_n;
    end
  end

  // Sample pin levels; a disabled input buffer reads as low.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pinState_q <= '0;
      pinPrev_q <= '0;
    end else begin
      for (int i = 0; i < gpio_port_pkg::NUM_PINS; i++) begin
        pinState_q[i] <= padIn[i] && drive[i].inEn;
      end
      pinPrev_q <= pinState_q;
    end
  end

  assign pinLevel = pinState_q;

  // Any change of an enabled pin's sampled level is an event.
  always_comb begin
    for (int i = 0; i < gpio_port_pkg::NUM_PINS; i++) begin
      pinEvent[i] = (pinState_q[i] != pinPrev_q[i]) && intEn_q[i / PPP][i % PPP];
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int p = 0; p < NP; p++) begin
        intStat_q[p] <= gpio_port_pkg::RST_INT;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        automatic logic [7:0] clr = '0;
        automatic logic [7:0] set = '0;
        if (wrStrobe && portHit && portSel == 2'(p) &&
            regOfs == gpio_port_pkg::OFS_INT_STATUS && wb_sel_i[0]) begin
          clr = wb_dat_i[7:0];
        end
        set[PPP-1:0] = pinEvent[p*PPP +: PPP];
        intStat_q[p] <= (intStat_q[p] & ~clr) | set;
      end
    end
  end

  // One level request per port, and their union.
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      portIrq[p] = |(intStat_q[p] & intMask_q[p]);
    end
    irq = |portIrq;
  end
endmodule
`default_nettype wire

// file: gpio_port_pkg.sv
// Purpose: Shared constants and carrier types for the general-purpose I/O port block.
// Assumes: A 32-bit classic Wishbone register bus and a single 250 MHz clock.
// Notes: Each port occupies one 0x20-byte window; only the low four bits of a port carry pins.
`default_nettype none
package gpio_port_pkg;
  // Pin and port geometry.
  localparam int NUM_PINS = 12;
  localparam int NUM_PORTS = 3;
  localparam int PORT_WIDTH = 8;
  localparam int PINS_PER_PORT = 4;
  localparam int MODE_BITS = 3;
  localparam int SEL_BITS = 2;
  localparam int NUM_SOURCES = 3;
  // Bus geometry.
  localparam int ADR_BITS = 8;
  localparam int DAT_BITS = 32;
  // Register offsets within one port window.
  localparam logic [4:0] OFS_DATA_OUT = 5'h00;
  localparam logic [4:0] OFS_PIN_STATE = 5'h04;
  localparam logic [4:0] OFS_DRIVE_MODE = 5'h08;
  localparam logic [4:0] OFS_BUF_CTRL = 5'h0c;
  localparam logic [4:0] OFS_SRC_SEL = 5'h10;
  localparam logic [4:0] OFS_INT_EN = 5'h14;
  localparam logic [4:0] OFS_INT_STATUS = 5'h18;
  localparam logic [4:0] OFS_INT_MASK = 5'h1c;
  // Port window placement and the global hold register.
  localparam logic [7:0] PORT_STRIDE = 8'h20;
  localparam logic [7:0] ADR_HOLD = 8'h60;
  // Buffer control field positions: input enable, output enable, LVTTL, fast slew.
  localparam int BUF_IE_POS = 0;
  localparam int BUF_OE_POS = 8;
  localparam int BUF_LVTTL_POS = 16;
  localparam int BUF_SLEW_POS = 24;
  // Masks of the bits that exist; the rest read as zero.
  localparam logic [7:0] PIN_MASK = 8'h0f;
  localparam logic [23:0] MODE_MASK = 24'h000fff;
  localparam logic [31:0] BUF_MASK = 32'h0f0f0f0f;
  localparam logic [15:0] SEL_MASK = 16'h00ff;
  // Values after reset: analog mode, all buffers off, data register source.
  localparam logic [7:0] RST_DATA_OUT = 8'h00;
  localparam logic [23:0] RST_DRIVE_MODE = 24'h000000;
  localparam logic [31:0] RST_BUF_CTRL = 32'h00000000;
  localparam logic [15:0] RST_SRC_SEL = 16'h0000;
  localparam logic [7:0] RST_INT = 8'h00;
  // Drive configuration codes.
  localparam logic [2:0] MODE_ANALOG = 3'h0;
  localparam logic [2:0] MODE_INPUT = 3'h1;
  localparam logic [2:0] MODE_WUP_SDN = 3'h2;
  localparam logic [2:0] MODE_SUP_WDN = 3'h3;
  localparam logic [2:0] MODE_OD_SDN = 3'h4;
  localparam logic [2:0] MODE_OD_SUP = 3'h5;
  localparam logic [2:0] MODE_SUP_SDN = 3'h6;
  localparam logic [2:0] MODE_WUP_WDN = 3'h7;

  // Per-pin control as set by software and the source matrix.
  typedef struct packed {
    logic [2:0] mode;
    logic inEn;
    logic outEn;
    logic dout;
  } pin_ctrl_type;

  // Per-pin pad drive as seen by the pad ring.
  typedef struct packed {
    logic strongOut;
    logic strongOe;
    logic weakUp;
    logic weakDown;
    logic inEn;
  } pad_drive_type;
endpackage
`default_nettype wire

// file: gpio_port_props.sv
// Purpose: Port-level checks for the general-purpose I/O block.
// Assumes: One clock domain with reset_n synchronous and active low.
// Notes: Bound into gpio_port at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [11:0] padOe,
  input wire logic [11:0] padWeakUp,
  input wire logic [11:0] padWeakDown,
  input wire logic [11:0] padInEn,
  input wire logic [11:0] pinLevel,
  input wire logic [2:0] portIrq,
  input wire logic irq
);
  logic req;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // A request still waiting for its acknowledge.
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Bus handshake: one cycle to answer, one cycle of acknowledge, none unasked.
  a_ack_latency: assert property (req |=> wb_ack_o) else $error("ack not one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_no_stray: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack unasked");
  a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i > 8'h60 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // Leaving reset, every buffer and pull is still off.
  a_reset_quiet: assert property ($rose(reset_n) |-> (padOe | padWeakUp | padWeakDown | padInEn) == 12'h0)
    else $error("buffers on after reset");
  a_irq_merge: assert property (irq == |portIrq) else $error("irq not the merge of port requests");
  // Port 2's request rises only after a change on pins 8 to 11 or a register write.
  a_irq_cause: assert property ($rose(portIrq[2]) |-> $past(pinLevel[11:8]) != $past(pinLevel[11:8], 2)
    || $past(wb_ack_o && wb_we_i)) else $error("port request without cause");
  // Drive enables move only two edges after a committed write.
  a_oe_by_write: assert property ($changed(padOe) |-> $past(wb_ack_o && wb_we_i, 2))
    else $error("output enable moved without write");
  c_irq: cover property ($rose(irq));
  c_unmapped: cover property (req && !wb_we_i && wb_adr_i > 8'h60);
  c_oe: cover property ($rose(padOe[0]));
endmodule
bind gpio_port gpio_port_props i_gpio_port_props (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .padOe(padOe), .padWeakUp(padWeakUp), .padWeakDown(padWeakDown),
  .padInEn(padInEn), .pinLevel(pinLevel), .portIrq(portIrq), .irq(irq));
`default_nettype wire

// file: test_general_purpose_io_port.sv
// Purpose: Self-checking bench for the I/O block over classic Wishbone.
// Assumes: 250 MHz clock, reset_n held low for two cycles at start.
// Notes: Register rows run first; pad, matrix, hold, interrupt and reset cases follow.
`timescale 1ns/1ps
`default_nettype none
module test_general_purpose_io_port;
  typedef struct packed {logic [7:0] adr; logic [31:0] wd; logic [31:0] rst; logic [31:0] rd;} row_type;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [11:0] extEn = 12'h000;
  logic [11:0] extVal = 12'h000;
  logic [2:0][11:0] periph = '0;
  logic [31:0] rdat, q;
  logic ack, irq;
  logic [11:0] padIn, padOut, padOe, padUp, padDn, padIe, padLv, padSf, pinLevel;
  logic [2:0] portIrq;
  int num_errors = 0;
  int n_checks = 0;
  row_type rows [8] = '{'{8'h00, '1, 0, 32'hf}, '{8'h28, '1, 0, 32'hfff}, '{8'h4c, '1, 0, 32'h0f0f0f0f},
    '{8'h10, '1, 0, 32'hff}, '{8'h34, '1, 0, 32'hf}, '{8'h3c, '1, 0, 32'hf}, '{8'h60, '1, 0, 32'h1},
    '{8'h70, '1, 0, 0}};
  gpio_port i_gpio_port (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .padIn(padIn),
    .padOut(padOut), .padOe(padOe), .padWeakUp(padUp), .padWeakDown(padDn), .padInEn(padIe),
    .padLvttl(padLv), .padSlewFast(padSf), .periphOut(periph), .pinLevel(pinLevel),
    .portIrq(portIrq), .irq(irq));
  gpio_pad_board i_gpio_pad_board (.clk(clk), .padOut(padOut), .padOe(padOe), .padWeakUp(padUp),
    .padWeakDown(padDn), .extEn(extEn), .extVal(extVal), .padIn(padIn));
  initial begin
    forever #2 clk = ~clk;
  end
  // One classic cycle, held until ack is sampled high.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    r = rdat;
    if (n >= 16) num_errors++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic chk_pad(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  // Lets pad flops and the pin sampler catch up.
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask
  function automatic logic oeWanted(input int m, input int d);
    case (m)
      2, 4: return d == 0;
      3, 5: return d == 1;
      6: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic levelKnown(input int m, input int d);
    return m == 2 || m == 3 || m == 6 || (m == 4 && d == 0) || (m == 5 && d == 1);
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog far beyond the few hundred cycles the run needs.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    close_out;
  end
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    settle;
    chk_pad("quiet", 12'h0, padOe | padUp | padDn | padIe);
    foreach (rows[i]) begin
      bus(1'b0, rows[i].adr, 32'h0, q);
      chk_word("reset value", rows[i].rst, q);
      wr(rows[i].adr, rows[i].wd);
      bus(1'b0, rows[i].adr, 32'h0, q);
      chk_word("readback", rows[i].rd, q);
      wr(rows[i].adr, rows[i].rst);
    end
    // Every drive code on pin 0 with both data values.
    wr(8'h0c, 32'h101);
    for (int m = 0; m < 8; m++) begin
      for (int d = 0; d < 2; d++) begin
        wr(8'h08, 32'(m));
        wr(8'h00, 32'(d));
        settle;
        chk_pad("drive", {11'h0, oeWanted(m, d)}, padOe);
        if (levelKnown(m, d)) chk_pad("level", 12'(d), {11'h0, pinLevel[0]});
      end
    end
    // The loop leaves weak-both mode with data high: only the weak pull-up is on.
    chk_pad("weak up", 12'h001, padUp);
    chk_pad("weak down", 12'h000, padDn);
    chk_pad("input enable", 12'h001, padIe);
    wr(8'h0c, 32'h1);
    wr(8'h08, 32'h6);
    settle;
    chk_pad("oe off", 12'h0, padOe);
    wr(8'h2c, 32'h0a050000);
    settle;
    chk_pad("lvttl", 12'h050, padLv);
    chk_pad("slew", 12'h0a0, padSf);
    wr(8'h0c, 32'h101);
    wr(8'h00, 32'h0);
    for (int s = 1; s < 4; s++) begin
      wr(8'h10, 32'(s));
      periph <= 36'h1 << (12 * (s - 1));
      settle;
      chk_pad("matrix", 12'h1, {11'h0, padOut[0]});
    end
    wr(8'h10, 32'h0);
    settle;
    wr(8'h60, 32'h1);
    wr(8'h00, 32'h1);
    settle;
    chk_pad("held", 12'h0, {11'h0, padOut[0]});
    wr(8'h60, 32'h0);
    settle;
    chk_pad("released", 12'h1, {11'h0, padOut[0]});
    // Pin 8 as an input toggled by the board.
    wr(8'h48, 32'h1);
    wr(8'h4c, 32'h1);
    extEn <= 12'h100;
    settle;
    extVal <= 12'h100;
    settle;
    bus(1'b0, 8'h44, 32'h0, q);
    chk_word("pin state", 32'h1, q);
    bus(1'b0, 8'h58, 32'h0, q);
    chk_word("status off", 32'h0, q);
    wr(8'h54, 32'h1);
    wr(8'h5c, 32'h1);
    extVal <= 12'h000;
    settle;
    bus(1'b0, 8'h58, 32'h0, q);
    chk_word("status set", 32'h1, q);
    chk_pad("port irq", 12'h004, {9'h0, portIrq});
    wr(8'h5c, 32'h0);
    settle;
    chk_pad("masked", 12'h000, {9'h0, portIrq});
    wr(8'h5c, 32'h1);
    wr(8'h58, 32'h1);
    settle;
    bus(1'b0, 8'h58, 32'h0, q);
    chk_word("cleared", 32'h0, q);
    chk_pad("irq low", 12'h000, {11'h0, irq});
    // A reset in mid-run drops every buffer at once.
    wr(8'h08, 32'h6);
    settle;
    reset_n <= 1'b0;
    #1;
    chk_pad("in reset", 12'h0, padOe | padUp | padDn | padIe);
    @(posedge clk);
    reset_n <= 1'b1;
    settle;
    chk_pad("after reset", 12'h0, padOe | padUp | padDn | padIe);
    bus(1'b0, 8'h08, 32'h0, q);
    chk_word("mode reset", 32'h0, q);
    close_out;
  end
endmodule
`default_nettype wire
